/* hdl/dmx_pkg.sv */
package dmx_pkg;
    // Datapath widths
    localparam int ACC_W  = 40;
    localparam int DATA_W = 16;
    localparam int PROD_W = 33;
    localparam int MUL_W  = 32;

    // Core configuration bit positions
    localparam int CFG_FRAC     = 0;
    localparam int CFG_ROUND    = 1;
    localparam int CFG_WIDTH    = 4;
    localparam int CFG_STORESAT = 5;
    localparam int CFG_CLIP_B   = 6;
    localparam int CFG_CLIP_A   = 7;
    localparam int CFG_UNSIGNED = 12;

    // Accumulator bit positions
    localparam int SIGN_BIT  = 39;
    localparam int GUARD_LO  = 32;
    localparam int FRAC_SIGN = 31;
    localparam int HIGH_LO   = 16;
    localparam int BYTE_W    = 8;

    // Saturation limits
    localparam logic [ACC_W-1:0] SAT40_POS = 40'h7F_FFFF_FFFF;
    localparam logic [ACC_W-1:0] SAT40_NEG = 40'h80_0000_0000;
    localparam logic [ACC_W-1:0] SAT32_POS = 40'h00_7FFF_FFFF;
    localparam logic [ACC_W-1:0] SAT32_NEG = 40'hFF_8000_0000;
    localparam logic [ACC_W-1:0] ACC_ZERO  = 40'h00_0000_0000;
    localparam logic [DATA_W-1:0] STORE_POS  = 16'h7FFF;
    localparam logic [DATA_W-1:0] STORE_NEG  = 16'h8000;
    localparam logic [DATA_W-1:0] ROUND_HALF = 16'h8000;

    // Operation classes issued by the decoder
    typedef enum logic [3:0] {
        OP_NONE,
        OP_CLEAR,
        OP_MPY,
        OP_MPY_NEG,
        OP_MAC,
        OP_MSC,
        OP_SQD_LOAD,
        OP_SQD_ACC,
        OP_ACC_ADD,
        OP_ACC_SUB,
        OP_ACC_NEG,
        OP_LOAD_SHIFTED,
        OP_ADD_SHIFTED,
        OP_PREFETCH_WB,
        OP_STORE,
        OP_MCU_MUL
    } dmx_op_t;
endpackage

/* hdl/dmx_multiplier.sv */
`timescale 1ns/1ps
module dmx_multiplier
    import dmx_pkg::*;
(
    input  wire logic [dmx_pkg::DATA_W-1:0] opA,
    input  wire logic [dmx_pkg::DATA_W-1:0] opB,
    input  wire logic                       diffMode,
    input  wire logic                       unsignedMode,
    input  wire logic                       fracMode,
    output logic      [dmx_pkg::ACC_W-1:0]  product
);
    logic signed [DATA_W:0]    extA;
    logic signed [DATA_W:0]    extB;
    logic signed [2*DATA_W+1:0] full;
    logic        [PROD_W-1:0]  scaled;

    // Operand extension, square difference shares both inputs
    always_comb begin
        if (diffMode) begin
            extA = $signed({opA[DATA_W-1], opA})
                 - $signed({opB[DATA_W-1], opB});
            extB = extA;
        end else begin
            extA = {(~unsignedMode) & opA[DATA_W-1], opA};
            extB = {(~unsignedMode) & opB[DATA_W-1], opB};
        end
        full = extA * extB;
        // Fractional result drops the duplicated sign bit
        if (fracMode) begin
            scaled = {full[PROD_W-2:0], 1'b0};
        end else begin
            scaled = full[PROD_W-1:0];
        end
        product = {{(ACC_W-PROD_W){scaled[PROD_W-1]}}, scaled};
    end
endmodule

/* hdl/dmx_store_path.sv */
`timescale 1ns/1ps
module dmx_store_path
    import dmx_pkg::*;
(
    input  wire logic [dmx_pkg::ACC_W-1:0]  accValue,
    input  wire logic                       roundEn,
    input  wire logic                       convergent,
    input  wire logic                       clipEn,
    output logic      [dmx_pkg::DATA_W-1:0] storeWord
);
    logic [DATA_W-1:0]       lowWord;
    logic                    bump;
    logic signed [ACC_W-HIGH_LO:0] upper;

    // Rounding of the high word, then 1.15 clipping
    always_comb begin
        lowWord = accValue[HIGH_LO-1:0];
        bump    = roundEn & lowWord[DATA_W-1];
        if (convergent && lowWord == ROUND_HALF) begin
            bump = roundEn & accValue[HIGH_LO];
        end
        upper = $signed({accValue[ACC_W-1], accValue[ACC_W-1:HIGH_LO]})
              + $signed({{(ACC_W-HIGH_LO){1'b0}}, bump});
        storeWord = upper[DATA_W-1:0];
        if (clipEn && !accValue[SIGN_BIT]
            && upper > $signed({{(ACC_W-HIGH_LO-DATA_W+1){1'b0}},
                                STORE_POS})) begin
            storeWord = STORE_POS;
        end else if (clipEn && accValue[SIGN_BIT]
            && upper < $signed({{(ACC_W-HIGH_LO-DATA_W+1){1'b1}},
                                STORE_NEG})) begin
            storeWord = STORE_NEG;
        end
    end
endmodule

/* hdl/dmx_mac_datapath.sv */
`timescale 1ns/1ps
// How it works
// - Multiplier operands get a 17th bit: zero if unsigned, sign if signed.
// - Multiplier gives 33 bits, sign-extended to 40 before the adder.
// - Scaler gives 1.31 fractional or 32-bit integer per config bit.
// - Integer multiply gives 16-bit result from bytes, 32-bit from words.
// - Accumulator A or B is source and target; shifted data may be added.
// - Adder has zero-select input; subtract complements data, low borrow.
// - Adder pass sets guard flag if bits 39..32 disagree, else clears; 32-bit clip mode keeps it clear.
// - A newly set guard flag with its trap enable raises a trap request.
// - Clip flag set by adder on range overflow, cleared only by software.
// - Without clipping, clip flag means bit 39 overflow; may trap.
// - Combined guard and clip flags are the OR of both accumulators.
// - Clipping uses sum, overflow, per-accumulator enables and width bit.
// - 40-bit mode clamps bit 39 overflow to 9.31 limits and flags it.
// - 32-bit mode clamps bit 31 overflow to 1.31 limits; no guard flags.
// - With clipping off the sum wraps and bit 39 overflow sets clip flag.
// - Config supplies frac, sign, round, clip enables, store clip, width.
// - Accumulator add, subtract and negate need no other operand.
// - Clear, multiply loads, accumulate, square diff; some write back.
// - Enabled store clipping forces out-of-range words to 0x7FFF or 0x8000.
// - Convergent round at halfway low word increments only if bit 16 is one.
module dmx_mac_datapath
    import dmx_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       opValid,
    input  wire dmx_pkg::dmx_op_t           opCode,
    input  wire logic                       accSelB,
    input  wire logic [dmx_pkg::DATA_W-1:0] xData,
    input  wire logic [dmx_pkg::DATA_W-1:0] yData,
    input  wire logic [dmx_pkg::ACC_W-1:0]  shiftData,
    input  wire logic                       byteMode,
    input  wire logic                       writeBackReq,
    input  wire logic                       storeRound,
    input  wire logic [dmx_pkg::DATA_W-1:0] coreConfig,
    input  wire logic                       guardTrapEnableA,
    input  wire logic                       guardTrapEnableB,
    input  wire logic                       catastrophicTrapEnable,
    input  wire logic                       clipClearA,
    input  wire logic                       clipClearB,
    output logic      [dmx_pkg::ACC_W-1:0]  accumulatorA,
    output logic      [dmx_pkg::ACC_W-1:0]  accumulatorB,
    output logic                            guardOvfA,
    output logic                            guardOvfB,
    output logic                            clipFlagA,
    output logic                            clipFlagB,
    output logic                            guardOvfAny,
    output logic                            clipFlagAny,
    output logic                            trapRequest,
    output logic      [dmx_pkg::MUL_W-1:0]  mulResult,
    output logic                            mulValid,
    output logic      [dmx_pkg::DATA_W-1:0] storeData,
    output logic                            storeValid
);
    typedef struct packed {
        logic [ACC_W-1:0]  accumulator_a;
        logic [ACC_W-1:0]  accumulator_b;
        logic              ovfA;
        logic              ovfB;
        logic              clipA;
        logic              clipB;
        logic              trap;
        logic [MUL_W-1:0]  mul;
        logic              mulOk;
        logic [DATA_W-1:0] store;
        logic              storeOk;
    } dmx_state_t;

    dmx_state_t st;
    dmx_state_t next_st;

    logic [ACC_W-1:0]  tgtAcc;
    logic [ACC_W-1:0]  otherAcc;
    logic [ACC_W-1:0]  product;
    logic [DATA_W-1:0] mulA;
    logic [DATA_W-1:0] mulB;
    logic              isUnsigned;
    logic              fracMode;
    logic [ACC_W-1:0]  addA;
    logic [ACC_W-1:0]  addData;
    logic [ACC_W-1:0]  addB;
    logic [ACC_W-1:0]  sum;
    logic              addPass;
    logic              zeroSel;
    logic              subtract;
    logic              carryIn;
    logic              ovf39;
    logic              ovf31;
    logic              guardHit;
    logic              trueSign;
    logic              clipEn;
    logic              superMode;
    logic [ACC_W-1:0]  result;
    logic              newGuard;
    logic              newClip;
    logic [ACC_W-1:0]  storeSrc;
    logic [DATA_W-1:0] storeWord;
    logic              storeRoundEn;
    logic              doStore;

    // Accumulator routing
    // target select
    assign tgtAcc     = accSelB ? st.accumulator_b : st.accumulator_a;
    assign otherAcc   = accSelB ? st.accumulator_a : st.accumulator_b;
    assign isUnsigned = coreConfig[CFG_UNSIGNED];
    assign fracMode   = coreConfig[CFG_FRAC] && opCode != OP_MCU_MUL;

    // Byte operands are pre-extended to a word
    // byte or word operands
    always_comb begin
        mulA = xData;
        mulB = yData;
        if (opCode == OP_MCU_MUL && byteMode) begin
            mulA = {{BYTE_W{~isUnsigned & xData[BYTE_W-1]}},
                    xData[BYTE_W-1:0]};
            mulB = {{BYTE_W{~isUnsigned & yData[BYTE_W-1]}},
                    yData[BYTE_W-1:0]};
        end
    end

    dmx_multiplier uMul (
        .opA          (mulA),
        .opB          (mulB),
        .diffMode     (opCode == OP_SQD_LOAD || opCode == OP_SQD_ACC),
        .unsignedMode (isUnsigned),
        .fracMode     (fracMode),
        .product      (product)
    );

    // Operand selection for the adder per operation
    // product, accumulator or shifted data operands
    always_comb begin
        addPass  = 1'b1;
        zeroSel  = 1'b0;
        subtract = 1'b0;
        addData  = product;
        case (opCode)
            OP_CLEAR: begin
                zeroSel = 1'b1;
                addData = ACC_ZERO;
            end
            OP_MPY, OP_SQD_LOAD: zeroSel = 1'b1;
            OP_MPY_NEG: begin
                zeroSel  = 1'b1;
                subtract = 1'b1;
            end
            OP_MAC, OP_SQD_ACC: zeroSel = 1'b0;
            OP_MSC: subtract = 1'b1;
            OP_ACC_ADD: addData = otherAcc;
            OP_ACC_SUB: begin
                addData  = otherAcc;
                subtract = 1'b1;
            end
            OP_ACC_NEG: begin
                zeroSel  = 1'b1;
                subtract = 1'b1;
                addData  = tgtAcc;
            end
            OP_LOAD_SHIFTED: begin
                zeroSel = 1'b1;
                addData = shiftData;
            end
            OP_ADD_SHIFTED: addData = shiftData;
            default: addPass = 1'b0;
        endcase
    end

    // 40-bit adder: true data with carry low, or complement with borrow low
    // zero input and complement
    assign addA    = zeroSel ? ACC_ZERO : tgtAcc;
    assign addB    = subtract ? ~addData : addData;
    assign carryIn = subtract;
    assign sum     = addA + addB + {{(ACC_W-1){1'b0}}, carryIn};

    // Overflow detection on the raw sum
    assign ovf39    = (addA[SIGN_BIT] == addB[SIGN_BIT])
                   && (sum[SIGN_BIT] != addA[SIGN_BIT]);
    assign trueSign = ovf39 ? addA[SIGN_BIT] : sum[SIGN_BIT];
    assign guardHit = !((&sum[SIGN_BIT:GUARD_LO])
                     || !(|sum[SIGN_BIT:GUARD_LO]));
    assign ovf31    = ovf39 || !((&sum[SIGN_BIT:FRAC_SIGN])
                     || !(|sum[SIGN_BIT:FRAC_SIGN]));

    // mode from per-accumulator enable and width bit
    assign clipEn    = accSelB ? coreConfig[CFG_CLIP_B]
                               : coreConfig[CFG_CLIP_A];
    assign superMode = coreConfig[CFG_WIDTH];

    // Saturation decision and new flag values
    always_comb begin
        result   = sum;
        newGuard = guardHit;
        newClip  = 1'b0;
        if (clipEn && superMode) begin
            if (ovf39) begin
                result   = trueSign ? SAT40_NEG : SAT40_POS;
                newClip  = 1'b1;
                newGuard = 1'b1; // Clamped value always fills guard bits
            end
        end else if (clipEn) begin
            // 1.31 limits, guard flag held low
            newGuard = 1'b0;
            if (ovf31) begin
                result  = trueSign ? SAT32_NEG : SAT32_POS;
                newClip = 1'b1;
            end
        end else begin
            newClip = ovf39;
        end
    end

    // Store source: target for stores, other accumulator for write-back
    assign storeSrc     = (opCode == OP_STORE) ? tgtAcc : otherAcc;
    assign storeRoundEn = (opCode == OP_STORE) ? storeRound : 1'b1;
    assign doStore = opValid && ((opCode == OP_STORE)
                  || (writeBackReq && (opCode == OP_CLEAR
                  || opCode == OP_PREFETCH_WB || opCode == OP_MSC
                  || opCode == OP_MAC)));

    dmx_store_path uStore (
        .accValue   (storeSrc),
        .roundEn    (storeRoundEn),
        .convergent (coreConfig[CFG_ROUND]),
        .clipEn     (coreConfig[CFG_STORESAT]),
        .storeWord  (storeWord)
    );

    // Next state of the whole datapath
    always_comb begin
        next_st         = st;
        next_st.trap    = 1'b0;
        next_st.mulOk   = 1'b0;
        next_st.storeOk = 1'b0;
        if (clipClearA) begin
            next_st.clipA = 1'b0;
        end
        if (clipClearB) begin
            next_st.clipB = 1'b0;
        end
        if (opValid && addPass) begin
            if (accSelB) begin
                next_st.accumulator_b = result;
                next_st.ovfB = newGuard;
                next_st.clipB = next_st.clipB | newClip;
            end else begin
                next_st.accumulator_a = result;
                next_st.ovfA = newGuard;
                next_st.clipA = next_st.clipA | newClip;
            end
            next_st.trap = (newGuard && (accSelB ? guardTrapEnableB
                                                 : guardTrapEnableA))
                        || (!clipEn && ovf39 && catastrophicTrapEnable);
        end
        if (opValid && opCode == OP_MCU_MUL) begin
            next_st.mulOk = 1'b1;
            next_st.mul   = byteMode
                ? {{(MUL_W-DATA_W){1'b0}}, product[DATA_W-1:0]}
                : product[MUL_W-1:0];
        end
        if (doStore) begin
            next_st.storeOk = 1'b1;
            next_st.store   = storeWord;
        end
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign accumulatorA = st.accumulator_a;
    assign accumulatorB = st.accumulator_b;
    assign guardOvfA    = st.ovfA;
    assign guardOvfB    = st.ovfB;
    assign clipFlagA    = st.clipA;
    assign clipFlagB    = st.clipB;
    assign guardOvfAny  = st.ovfA | st.ovfB;
    assign clipFlagAny  = st.clipA | st.clipB;
    assign trapRequest  = st.trap;
    assign mulResult    = st.mul;
    assign mulValid     = st.mulOk;
    assign storeData    = st.store;
    assign storeValid   = st.storeOk;

    // Checks on the datapath behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_hit_a;
        opValid && addPass && !accSelB;
    endsequence

    sequence s_super_a;
        s_hit_a and (coreConfig[CFG_CLIP_A] && superMode && ovf39);
    endsequence

    sequence s_narrow_a;
        s_hit_a and (coreConfig[CFG_CLIP_A] && !superMode);
    endsequence

    property p_clip_sticky;
        clipFlagA && !clipClearA |=> clipFlagA;
    endproperty
    a_clip_sticky: assert property (p_clip_sticky)
        else $error("clip flag A dropped without a clear");

    property p_any_or;
        guardOvfAny == (guardOvfA || guardOvfB)
            && clipFlagAny == (clipFlagA || clipFlagB);
    endproperty
    a_any_or: assert property (p_any_or)
        else $error("combined flags differ from OR of flags");

    property p_super;
        s_super_a |=> clipFlagA
            && (accumulatorA == SAT40_POS || accumulatorA == SAT40_NEG);
    endproperty
    a_super: assert property (p_super)
        else $error("40-bit overflow not clamped on A");

    property p_narrow;
        s_narrow_a |=> !guardOvfA;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("guard flag set in 32-bit mode");

    property p_wrap;
        s_hit_a and (!coreConfig[CFG_CLIP_A] && ovf39)
            |=> clipFlagA && accumulatorA == $past(sum);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("catastrophic overflow did not wrap and flag");

    property p_guard_trap;
        s_hit_a and (guardTrapEnableA && newGuard)
            |=> guardOvfA && trapRequest;
    endproperty
    a_guard_trap: assert property (p_guard_trap)
        else $error("guard overflow trap missing");

    property p_clear;
        opValid && opCode == OP_CLEAR && accSelB
            |=> accumulatorB == ACC_ZERO && !guardOvfB;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero accumulator B");

    property p_byte_mul;
        opValid && opCode == OP_MCU_MUL && byteMode
            |=> mulValid && mulResult[MUL_W-1:DATA_W] == '0 ##1 !mulValid
            or mulValid && mulResult[MUL_W-1:DATA_W] == '0 ##1 mulValid;
    endproperty
    a_byte_mul: assert property (p_byte_mul)
        else $error("byte multiply result wider than 16 bits");

    property p_store_clip;
        doStore && coreConfig[CFG_STORESAT] && !storeSrc[SIGN_BIT]
            |=> storeValid && !storeData[DATA_W-1];
    endproperty
    a_store_clip: assert property (p_store_clip)
        else $error("positive store clipped to negative value");
endmodule

/* tb/dmx_wreg_model.sv */
`timescale 1ns/1ps
// Decoder side: two operand registers and the core configuration word
module dmx_wreg_model
    import dmx_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       loadEn,
    input  wire logic [dmx_pkg::DATA_W-1:0] loadX,
    input  wire logic [dmx_pkg::DATA_W-1:0] loadY,
    input  wire logic [dmx_pkg::DATA_W-1:0] loadConfig,
    input  wire logic                       xIdx,
    input  wire logic                       yIdx,
    output logic      [dmx_pkg::DATA_W-1:0] xData,
    output logic      [dmx_pkg::DATA_W-1:0] yData,
    output logic      [dmx_pkg::DATA_W-1:0] coreConfig
);
    logic [DATA_W-1:0] regs [2];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regs[0] <= 16'h0000;
            regs[1] <= 16'h0000;
            coreConfig <= 16'h0000;
        end else if (loadEn) begin
            regs[0] <= loadX;
            regs[1] <= loadY;
            coreConfig <= loadConfig;
        end
    end

    // Operand read ports, same register twice gives a square
    assign xData = regs[xIdx];
    assign yData = regs[yIdx];
endmodule

/* tb/dmx_mac_datapath_bench.sv */
`timescale 1ns/1ps
module dmx_mac_datapath_bench;
    import dmx_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, opValid = 1'b0, accSelB = 1'b0;
    logic byteMode = 1'b0, writeBackReq = 1'b0, storeRound = 1'b0;
    logic guardTrapEnableA = 1'b0, guardTrapEnableB = 1'b0;
    logic catastrophicTrapEnable = 1'b0, clipClearA = 1'b0;
    logic clipClearB = 1'b0, loadEn = 1'b0, xIdx = 1'b0, yIdx = 1'b0;
    dmx_op_t opCode = OP_NONE;
    logic [15:0] loadX = 16'h0000, loadY = 16'h0000, loadConfig = 16'h0000;
    logic [39:0] shiftData = 40'h00_0000_0000;
    logic [15:0] xData, yData, coreConfig, storeData;
    logic [39:0] accumulatorA, accumulatorB;
    logic [31:0] mulResult;
    logic guardOvfA, guardOvfB, clipFlagA, clipFlagB, guardOvfAny;
    logic clipFlagAny, trapRequest, mulValid, storeValid;
    logic [39:0] ma = ACC_ZERO, mb = ACC_ZERO;
    logic ga = 1'b0, gb = 1'b0, ca = 1'b0, cb = 1'b0;
    logic [31:0] seed = 32'h22F52F84;
    int error_cnt = 0, comparisons = 0, cycles = 0;

    dmx_wreg_model u_regs (.clk(clk), .sys_rst(sys_rst), .loadEn(loadEn),
        .loadX(loadX), .loadY(loadY), .loadConfig(loadConfig), .xIdx(xIdx),
        .yIdx(yIdx), .xData(xData), .yData(yData), .coreConfig(coreConfig));

    dmx_mac_datapath u_dut (.clk(clk), .sys_rst(sys_rst), .opValid(opValid),
        .opCode(opCode), .accSelB(accSelB), .xData(xData), .yData(yData),
        .shiftData(shiftData), .byteMode(byteMode),
        .writeBackReq(writeBackReq), .storeRound(storeRound),
        .coreConfig(coreConfig), .guardTrapEnableA(guardTrapEnableA),
        .guardTrapEnableB(guardTrapEnableB),
        .catastrophicTrapEnable(catastrophicTrapEnable),
        .clipClearA(clipClearA), .clipClearB(clipClearB),
        .accumulatorA(accumulatorA), .accumulatorB(accumulatorB),
        .guardOvfA(guardOvfA), .guardOvfB(guardOvfB), .clipFlagA(clipFlagA),
        .clipFlagB(clipFlagB), .guardOvfAny(guardOvfAny),
        .clipFlagAny(clipFlagAny), .trapRequest(trapRequest),
        .mulResult(mulResult), .mulValid(mulValid), .storeData(storeData),
        .storeValid(storeValid));

    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt++;
            close_out();
        end
    end

    // Repeatable xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [191:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Counts: errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [39:0] prod(input logic [15:0] x, y, cfg);
        longint a, b;
        a = cfg[CFG_UNSIGNED] ? longint'(x) : longint'($signed(x));
        b = cfg[CFG_UNSIGNED] ? longint'(y) : longint'($signed(y));
        a = a * b;
        if (cfg[CFG_FRAC])
            a = a <<< 1;
        return {{7{a[32]}}, a[32:0]};
    endfunction

    function automatic logic [31:0] mcu(input logic [15:0] x, y,
                                        input logic uns, byt);
        longint a, b;
        a = uns ? longint'(x) : longint'($signed(x));
        b = uns ? longint'(y) : longint'($signed(y));
        if (byt) begin
            a = uns ? longint'(x[7:0]) : longint'($signed(x[7:0]));
            b = uns ? longint'(y[7:0]) : longint'($signed(y[7:0]));
        end
        a = a * b;
        return byt ? {16'h0000, a[15:0]} : a[31:0];
    endfunction

    // adder pass with overflow and clamping
    task automatic adder(input logic [39:0] a, b, input logic sub, ce, w40,
                         output logic [39:0] r, output logic g, ov, st);
        logic signed [40:0] s;
        s = sub ? $signed({a[39], a}) - $signed({b[39], b})
                : $signed({a[39], a}) + $signed({b[39], b});
        ov = s[40] != s[39];
        r = s[39:0];
        st = !ce && ov;
        if (ce && w40 && ov) begin
            r = s[40] ? SAT40_NEG : SAT40_POS;
            st = 1'b1;
        end
        if (ce && !w40 && s[40:31] != {10{s[40]}}) begin
            r = s[40] ? SAT32_NEG : SAT32_POS;
            st = 1'b1;
        end
        g = !(ce && !w40) && !(r[39:32] inside {8'h00, 8'hFF});
    endtask

    // Load operands, issue one op, then compare against the model
    task automatic do_op(input dmx_op_t op, input logic sel,
                         input logic [15:0] x, y, cfg,
                         input logic [39:0] sh, input logic sq);
        logic [39:0] a, b, t, o, r;
        logic g, ov, st, ce, sub, touch, tr, clrA, clrB;
        logic [31:0] rv, mr;
        rv = rnd();
        @(posedge clk);
        loadEn <= 1'b1;
        loadX <= x;
        loadY <= y;
        loadConfig <= cfg;
        @(posedge clk);
        loadEn <= 1'b0;
        opValid <= 1'b1;
        opCode <= op;
        accSelB <= sel;
        yIdx <= !sq;
        shiftData <= sh;
        byteMode <= rv[0];
        writeBackReq <= rv[1];
        storeRound <= rv[2];
        guardTrapEnableA <= rv[3];
        guardTrapEnableB <= rv[4];
        catastrophicTrapEnable <= rv[5];
        clrA = rv[8:6] == 3'h0;
        clrB = rv[11:9] == 3'h0;
        clipClearA <= clrA;
        clipClearB <= clrB;
        @(posedge clk);
        opValid <= 1'b0;
        clipClearA <= 1'b0;
        clipClearB <= 1'b0;
        #1;
        if (sq)
            y = x;
        t = sel ? mb : ma;
        o = sel ? ma : mb;
        ce = sel ? cfg[CFG_CLIP_B] : cfg[CFG_CLIP_A];
        a = op inside {OP_MAC, OP_MSC, OP_ACC_ADD, OP_ACC_SUB, OP_ADD_SHIFTED}
            ? t : ACC_ZERO;
        b = op inside {OP_MPY, OP_MPY_NEG, OP_MAC, OP_MSC} ? prod(x, y, cfg)
            : op inside {OP_ACC_ADD, OP_ACC_SUB} ? o : op == OP_ACC_NEG ? t
            : op inside {OP_LOAD_SHIFTED, OP_ADD_SHIFTED} ? sh : ACC_ZERO;
        sub = op inside {OP_MPY_NEG, OP_MSC, OP_ACC_SUB, OP_ACC_NEG};
        touch = !(op inside {OP_NONE, OP_STORE, OP_PREFETCH_WB, OP_MCU_MUL});
        adder(a, b, sub, ce, cfg[CFG_WIDTH], r, g, ov, st);
        tr = touch && ((g && (sel ? rv[4] : rv[3])) || (!ce && rv[5] && ov));
        if (touch && !sel) begin
            ma = r;
            ga = g;
        end
        if (touch && sel) begin
            mb = r;
            gb = g;
        end
        ca = (touch && !sel && st) || (ca && !clrA);
        cb = (touch && sel && st) || (cb && !clrB);
        check({accumulatorA, accumulatorB, guardOvfA, guardOvfB, clipFlagA,
               clipFlagB, guardOvfAny, clipFlagAny, trapRequest},
              {ma, mb, ga, gb, ca, cb, ga | gb, ca | cb, tr});
        mr = op == OP_MCU_MUL ? mcu(x, y, cfg[CFG_UNSIGNED], rv[0]) : 32'h0;
        check({mulValid, op == OP_MCU_MUL ? mulResult : 32'h0},
              {op == OP_MCU_MUL, mr});
        check(storeValid, op == OP_STORE || (rv[1] && op inside {OP_CLEAR,
              OP_PREFETCH_WB, OP_MSC, OP_MAC}));
    endtask

    // Reset, corner cases per clipping mode, then random traffic
    initial begin
        logic [31:0] r2, r3;
        logic [15:0] cfgv;
        dmx_op_t op;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        check({accumulatorA, accumulatorB, guardOvfA, guardOvfB, clipFlagA,
               clipFlagB, guardOvfAny, clipFlagAny, trapRequest, mulResult,
               mulValid, storeData, storeValid}, 160'h0);
        for (int m = 0; m < 3; m++) begin
            cfgv = m == 0 ? 16'h00D0 : m == 1 ? 16'h00C0 : 16'h0000;
            for (int k = 0; k < 2; k++) begin
                do_op(OP_LOAD_SHIFTED, k[0], 16'h0000, 16'h0000, cfgv,
                      k ? SAT32_POS : SAT40_POS, 1'b0);
                do_op(OP_ADD_SHIFTED, k[0], 16'h0000, 16'h0000, cfgv,
                      40'h00_0000_0001, 1'b0);
                do_op(OP_LOAD_SHIFTED, k[0], 16'h0000, 16'h0000, cfgv,
                      k ? SAT32_NEG : SAT40_NEG, 1'b0);
                do_op(OP_ACC_NEG, k[0], 16'h0000, 16'h0000, cfgv,
                      ACC_ZERO, 1'b0);
            end
        end
        for (int k = 0; k < 4; k++)
            do_op(OP_MPY, k[0], 16'h8000, 16'h8000,
                  {3'h0, k[1], 11'h000, k[0]}, ACC_ZERO, 1'b0);
        repeat (600) begin
            r2 = rnd();
            r3 = rnd();
            op = dmx_op_t'(r3[3:0]);
            if (op inside {OP_SQD_LOAD, OP_SQD_ACC})
                op = OP_MAC;
            do_op(op, r3[21], r2[31:16], r3[15:0], r2[15:0],
                  {r3[31:24], rnd()}, r3[20:16] == 5'h00);
        end
        close_out();
    end
endmodule
